// [src/ebi_map.svh]
// offsets, field positions, reset values and decode bounds of the external bus interface
// How it works
// [R1] multiplexed and plain cycles, memory or I/O
// [R2] dedicated address held t1 through t4
// [R3] shared bus carries address in t1 only
// [R4] after t1 shared bus carries data
// [R5] wide strobes: high=bhe_n|wr_n, low=a0|wr_n
// [R6] narrow variant: one strobe low per byte
// [R7] byte strobes travel with the dedicated address
// [R8] pseudo-static cycles only inside programmed low select
// [R9] peripheral registers decode as one 256-byte block
// [R10] narrow byte writes become 16-bit register transfers
// [R11] software reads peripheral registers as words only
// [R12] software avoids unaligned peripheral block accesses
// [R13] offsets 50h..66h reach the three timers
// [R14] offsets 20h..44h reach interrupt and watchdog
// [R15] offsets 10h..18h reach the synchronous serial port
// [R16] block base from relocation register, fixed reset
// [R17] relocation io bit picks I/O or memory space
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH

`define EBI_RELOC_OFFSET   8'hfe
`define EBI_RELOC_RESET    16'h20ff
`define EBI_RELOC_SLAVE_BIT 14
`define EBI_RELOC_IO_BIT   12
`define EBI_RELOC_RA_MSB   11
`define EBI_RELOC_RW_MASK  16'h5fff

`define EBI_TIMER_LO       8'h50
`define EBI_TIMER_HI       8'h66
`define EBI_INTC_LO        8'h20
`define EBI_INTC_HI        8'h44
`define EBI_SSP_LO         8'h10
`define EBI_SSP_HI         8'h18

`endif

// [src/ebi_pkg.sv]
// types shared by the external bus interface files
package ebi_pkg;

  typedef enum logic [2:0] {
    EBI_TGT_NONE,
    EBI_TGT_SSP,
    EBI_TGT_INTC,
    EBI_TGT_TIMER,
    EBI_TGT_RELOC
  } ebi_target_type;

  // core request; byte data is right-aligned in wdata[7:0]
  typedef struct packed {
    logic        write;
    logic        io;
    logic        word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } ebi_req_type;

  // settings owned by chip_select_control
  typedef struct packed {
    logic        lcs_enable;
    logic        psram_enable;
    logic [19:0] lcs_limit;
  } ebi_csc_type;

  // one transfer toward an on-chip peripheral register
  typedef struct packed {
    logic           strobe;
    logic           write;
    ebi_target_type target;
    logic [7:0]     offset;
    logic [15:0]    wdata;
  } ebi_prb_type;

  typedef struct packed {
    logic [19:0] a;
    logic [15:0] ad_out;
    logic        ad_oe;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        bhe_n;
    logic        io_or_memory_select;
  } ebi_pins_type;

endpackage : ebi_pkg

// [src/ebi_decode.sv]
// offset decoder of the peripheral register block
`timescale 1ns/100ps
`include "ebi_map.svh"

module ebi_decode
  import ebi_pkg::*;
(
  input  wire logic [7:0]     offset,
  output ebi_target_type      target
);

  always_comb
  begin
    if (offset == `EBI_RELOC_OFFSET)
      target = EBI_TGT_RELOC;
    else if (offset >= `EBI_TIMER_LO && offset <= `EBI_TIMER_HI)
      target = EBI_TGT_TIMER;  // [R13]
    else if (offset >= `EBI_INTC_LO && offset <= `EBI_INTC_HI)
      target = EBI_TGT_INTC;   // [R14]
    else if (offset >= `EBI_SSP_LO && offset <= `EBI_SSP_HI)
      target = EBI_TGT_SSP;    // [R15]
    else
      target = EBI_TGT_NONE;
  end

endmodule : ebi_decode

// [src/ebi_top.sv]
// external bus interface: external cycles, byte strobes and peripheral block decode
`timescale 1ns/100ps
`include "ebi_map.svh"

module ebi_top
  import ebi_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0
)
(
  input  wire logic            mclk,
  input  wire logic            rst_b,
  input  wire logic            ce,
  input  wire logic            req_valid,
  output logic                 req_ready,
  input  wire ebi_req_type     req,
  output logic                 resp_valid,
  output logic [15:0]          resp_rdata,
  input  wire ebi_csc_type     chip_select_control,
  output ebi_prb_type          prb,
  input  wire logic [15:0]     prb_rdata,
  output logic                 intc_slave_mode,
  output ebi_pins_type         pins,
  input  wire logic [15:0]     ad_in,
  input  wire logic            srdy,
  output logic                 whb_n,
  output logic                 wlb_n,
  output logic                 single_byte_write_n,
  output logic                 psram_cycle
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_TW,
    ST_T4,
    ST_PCB,
    ST_PCBR
  } ebi_state_type;

  ebi_state_type  state_reg;
  ebi_state_type  state_next;
  ebi_req_type    cur_reg;
  ebi_req_type    sel;
  logic           half_reg;
  logic           half_next;
  logic [15:0]    reloc_reg;
  logic [15:0]    ad_meta_reg;
  logic [15:0]    ad_sync_reg;
  logic           srdy_meta_reg;
  logic           srdy_sync_reg;
  logic           pcb_hit;
  logic [19:0]    cyc_addr;
  logic           lane_high;
  logic           last_half;
  ebi_target_type dec_target;
  ebi_pins_type   pins_reg;
  ebi_prb_type    prb_reg;
  logic [15:0]    rdata_reg;
  logic           resp_reg;
  logic           psram_reg;

  // request currently steering the pins; taken straight from the port on acceptance
  assign sel       = (state_reg == ST_IDLE) ? req : cur_reg;
  assign cyc_addr  = sel.addr + {19'h00000, half_next};
  assign lane_high = NARROW_BUS ? 1'b0 : cyc_addr[0];
  assign last_half = !(NARROW_BUS && cur_reg.word) || half_reg;

  // io space ignores the top four base bits
  always_comb
  begin
    if (reloc_reg[`EBI_RELOC_IO_BIT])  // [R17]
      pcb_hit = req.io && (req.addr[15:8] == reloc_reg[7:0]);  // [R16]
    else
      pcb_hit = !req.io && (req.addr[19:8] == reloc_reg[`EBI_RELOC_RA_MSB:0]);  // [R9] [R16]
  end

  ebi_decode u_decode (
    .offset (req.addr[7:0]),
    .target (dec_target)
  );

  // pins are asynchronous to mclk: two stages before anything looks
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ad_meta_reg   <= 16'h0000;
      ad_sync_reg   <= 16'h0000;
      srdy_meta_reg <= 1'b0;
      srdy_sync_reg <= 1'b0;
    end
    else if (ce)
    begin
      ad_meta_reg   <= ad_in;
      ad_sync_reg   <= ad_meta_reg;
      srdy_meta_reg <= srdy;
      srdy_sync_reg <= srdy_meta_reg;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    half_next  = half_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        half_next = 1'b0;
        if (req_valid)
          state_next = pcb_hit ? ST_PCB : ST_T1;  // [R1] [R9]
      end
      ST_T1:   state_next = ST_T2;
      ST_T2:   state_next = ST_T3;
      ST_T3,
      ST_TW:   state_next = srdy_sync_reg ? ST_T4 : ST_TW;
      ST_T4:
      begin
        if (last_half)
          state_next = ST_IDLE;
        else
        begin
          state_next = ST_T1;
          half_next  = 1'b1;  // [R6] narrow word goes out as two byte cycles
        end
      end
      ST_PCB:  state_next = ST_PCBR;
      ST_PCBR: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      half_reg  <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      half_reg  <= half_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      cur_reg <= '0;
    else if (ce && state_reg == ST_IDLE && req_valid)
      cur_reg <= req;
  end

  // external pins, all registered from the state being entered
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pins_reg.a                   <= 20'h00000;
      pins_reg.ad_out              <= 16'h0000;
      pins_reg.ad_oe               <= 1'b0;
      pins_reg.ale                 <= 1'b0;
      pins_reg.rd_n                <= 1'b1;
      pins_reg.wr_n                <= 1'b1;
      pins_reg.bhe_n               <= 1'b1;
      pins_reg.io_or_memory_select <= 1'b0;
    end
    else if (ce)
    begin
      pins_reg.ale  <= (state_next == ST_T1);
      pins_reg.rd_n <= !(!sel.write && (state_next == ST_T2 || state_next == ST_T3 || state_next == ST_TW));
      pins_reg.wr_n <= !(sel.write && (state_next == ST_T2 || state_next == ST_T3 || state_next == ST_TW));
      if (state_next == ST_T1)
      begin
        pins_reg.a                   <= cyc_addr;  // [R2] held until the next t1
        pins_reg.ad_out              <= cyc_addr[15:0];  // [R3]
        pins_reg.ad_oe               <= 1'b1;  // [R3]
        pins_reg.bhe_n               <= NARROW_BUS ? 1'b1 : !(sel.word || cyc_addr[0]);
        pins_reg.io_or_memory_select <= sel.io;  // [R1]
      end
      else if (state_next == ST_T2)
      begin
        pins_reg.ad_oe <= sel.write;  // [R4] released on reads
        if (NARROW_BUS)
          pins_reg.ad_out <= {8'h00, half_reg ? sel.wdata[15:8] : sel.wdata[7:0]};  // [R4]
        else if (sel.word)
          pins_reg.ad_out <= sel.wdata;  // [R4]
        else
          pins_reg.ad_out <= lane_high ? {sel.wdata[7:0], 8'h00} : {8'h00, sel.wdata[7:0]};  // [R4]
      end
      else if (state_next == ST_IDLE || state_next == ST_PCB)
        pins_reg.ad_oe <= 1'b0;
    end
  end

  // strobes are combined from registered pins, so they move with the address bus
  assign whb_n               = NARROW_BUS ? 1'b1 : (pins_reg.bhe_n | pins_reg.wr_n);  // [R5] [R7]
  assign wlb_n               = NARROW_BUS ? 1'b1 : (pins_reg.a[0] | pins_reg.wr_n);  // [R5] [R7]
  assign single_byte_write_n = NARROW_BUS ? pins_reg.wr_n : 1'b1;  // [R6] [R7]

  // pseudo-static cycles need an enabled low select and a memory address beneath its limit
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      psram_reg <= 1'b0;
    else if (ce)
    begin
      if (state_next == ST_T1)
        psram_reg <= !sel.io && chip_select_control.lcs_enable && chip_select_control.psram_enable && (cyc_addr < chip_select_control.lcs_limit);  // [R8]
      else if (state_next == ST_IDLE || state_next == ST_PCB)
        psram_reg <= 1'b0;
    end
  end

  // relocation register; writes clear reserved bits 15 and 13, but reset loads bit 13 as one
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      reloc_reg <= `EBI_RELOC_RESET;  // [R16]
    else if (ce && state_reg == ST_PCB && cur_reg.write && prb_reg.target == EBI_TGT_RELOC)
      reloc_reg <= prb_reg.wdata & `EBI_RELOC_RW_MASK;  // [R16] [R17]
  end

  // one-cycle register transfer; address bit 0 is dropped, unaligned use is undefined
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      prb_reg <= '0;
    else if (ce)
    begin
      prb_reg.strobe <= (state_next == ST_PCB) && (dec_target != EBI_TGT_RELOC) && (state_reg == ST_IDLE);
      if (state_reg == ST_IDLE && req_valid)
      begin
        prb_reg.write  <= req.write;
        prb_reg.target <= dec_target;  // [R9]
        prb_reg.offset <= {req.addr[7:1], 1'b0};  // [R12]
        prb_reg.wdata  <= req.wdata;  // [R10] always a full 16-bit transfer
      end
    end
  end

  // read data: narrow halves assemble low byte first; on the wide bus odd bytes come off the high lane
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rdata_reg <= 16'h0000;
    else if (ce)
    begin
      if (state_reg == ST_PCB)
        rdata_reg <= (prb_reg.target == EBI_TGT_RELOC) ? reloc_reg : prb_rdata;  // [R11]
      else if ((state_reg == ST_T3 || state_reg == ST_TW) && srdy_sync_reg && !cur_reg.write)
      begin
        if (NARROW_BUS && half_reg)
          rdata_reg[15:8] <= ad_sync_reg[7:0];
        else if (NARROW_BUS)
          rdata_reg <= {8'h00, ad_sync_reg[7:0]};
        else if (cur_reg.word)
          rdata_reg <= ad_sync_reg;
        else
          rdata_reg <= {8'h00, pins_reg.a[0] ? ad_sync_reg[15:8] : ad_sync_reg[7:0]};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      resp_reg <= 1'b0;
    else if (ce)
      resp_reg <= (state_reg == ST_PCBR) || (state_reg == ST_T4 && last_half);
  end

  assign req_ready       = ce && (state_reg == ST_IDLE);
  assign resp_valid      = resp_reg && ce;
  assign resp_rdata      = rdata_reg;
  assign prb             = prb_reg;
  assign pins            = pins_reg;
  assign psram_cycle     = psram_reg;
  assign intc_slave_mode = reloc_reg[`EBI_RELOC_SLAVE_BIT];

endmodule : ebi_top

// [test/ebi_chk.sv]
// port assertions of the external bus interface
`timescale 1ns/100ps
module ebi_chk
  import ebi_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0
)
(
  input wire logic         mclk,
  input wire logic         rst_b,
  input wire logic         resp_valid,
  input wire ebi_csc_type  chip_select_control,
  input wire ebi_prb_type  prb,
  input wire ebi_pins_type pins,
  input wire logic         whb_n,
  input wire logic         wlb_n,
  input wire logic         psram_cycle,
  input wire logic         single_byte_write_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_t1; pins.ale; endsequence
  sequence s_prb_done; !prb.strobe ##1 resp_valid; endsequence
  property p_whb; whb_n == (pins.bhe_n | pins.wr_n); endproperty
  // the narrow variant keeps both wide strobes parked high
  property p_wlb; wlb_n == (NARROW_BUS | pins.a[0] | pins.wr_n); endproperty
  property p_sbw; single_byte_write_n == (!NARROW_BUS | pins.wr_n); endproperty
  property p_hold; s_t1 |=> $stable(pins.a)[*3]; endproperty
  property p_t1; s_t1 |-> pins.ad_oe && pins.ad_out == pins.a[15:0] && pins.rd_n && pins.wr_n; endproperty
  property p_wdata; $fell(pins.wr_n) |-> $past(pins.ale) && pins.ad_oe; endproperty
  property p_wstb; !pins.wr_n |-> $stable(pins.a); endproperty
  property p_psram;
    psram_cycle |-> !pins.io_or_memory_select && chip_select_control.lcs_enable && chip_select_control.psram_enable && pins.a < chip_select_control.lcs_limit;
  endproperty
  property p_prb; prb.strobe |=> s_prb_done; endproperty
  property p_dec;
    prb.strobe |-> ((prb.offset inside {[8'h50:8'h66]}) == (prb.target == EBI_TGT_TIMER))
      && ((prb.offset inside {[8'h20:8'h44]}) == (prb.target == EBI_TGT_INTC))
      && ((prb.offset inside {[8'h10:8'h18]}) == (prb.target == EBI_TGT_SSP));
  endproperty
  a_whb: assert property (p_whb) else $error("high strobe wrong");
  a_wlb: assert property (p_wlb) else $error("low strobe wrong");
  a_sbw: assert property (p_sbw) else $error("single strobe wrong");
  a_hold: assert property (p_hold) else $error("address moved");
  a_t1: assert property (p_t1) else $error("bad first phase");
  a_wdata: assert property (p_wdata) else $error("write data late");
  a_wstb: assert property (p_wstb) else $error("strobe without address");
  a_psram: assert property (p_psram) else $error("pseudo-static outside region");
  a_prb: assert property (p_prb) else $error("block answer late");
  a_dec: assert property (p_dec) else $error("decode wrong");
endmodule : ebi_chk

bind ebi_top ebi_chk #(.NARROW_BUS(NARROW_BUS)) u_chk (.mclk, .rst_b, .resp_valid, .chip_select_control, .prb, .pins, .whb_n, .wlb_n,
  .psram_cycle, .single_byte_write_n);

// [test/ebi_mem_model.sv]
// partner model: external word memory with optional wait states
`timescale 1ns/100ps
module ebi_mem_model
  import ebi_pkg::*;
#(
  parameter int WAITS  = 3,
  parameter bit NARROW = 1'b0
)
(
  input  wire logic         mclk,
  input  wire ebi_pins_type pins,
  input  wire logic         slow,
  output logic [15:0]       ad_in,
  output logic              srdy
);
  logic [15:0] mem [256];
  logic [15:0] last_reg = 16'h0000;
  int          wait_cnt = 0;
  logic [15:0] rd_word;

  // a released bus shows a toggling copy so stale data never passes
  // the narrow variant moves one byte on the low lines, picked by address bit 0
  always_comb
  begin
    rd_word = mem[pins.a[8:1]];
    if (NARROW)
      rd_word = {8'h00, pins.a[0] ? rd_word[15:8] : rd_word[7:0]};
    ad_in = pins.ad_oe ? pins.ad_out : (!pins.rd_n ? rd_word : ~last_reg);
  end
  assign srdy = !(slow && pins.ale) && wait_cnt == 0;

  always @(posedge mclk)
  begin
    last_reg <= ad_in;
    if (pins.ale && slow)
      wait_cnt <= WAITS;
    else if (wait_cnt != 0)
      wait_cnt <= wait_cnt - 1;
    if (!pins.wr_n && NARROW && pins.a[0])
      mem[pins.a[8:1]][15:8] <= pins.ad_out[7:0];
    if (!pins.wr_n && !NARROW && !pins.bhe_n)
      mem[pins.a[8:1]][15:8] <= pins.ad_out[15:8];
    if (!pins.wr_n && !pins.a[0])
      mem[pins.a[8:1]][7:0] <= pins.ad_out[7:0];
  end
endmodule : ebi_mem_model

// [test/external_bus_interface_tb.sv]
// self-checking bench of the external bus interface
`timescale 1ns/100ps
module external_bus_interface_tb;
  import ebi_pkg::*;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic         ce = 1'b1;
  logic         req_valid = 1'b0;
  logic         slow = 1'b0;
  logic         hold = 1'b0;
  ebi_req_type  req = '0;
  ebi_csc_type  chip_select_control = '{1'b1, 1'b1, 20'h08000};
  logic [15:0]  prb_rdata = 16'h0000;
  logic         req_ready, resp_valid, intc_slave_mode, whb_n, wlb_n, srdy;
  logic [15:0]  resp_rdata, ad_in, wd, bd;
  logic [19:0]  adr;
  logic [16:0]  e;
  ebi_prb_type  prb;
  ebi_pins_type pins;
  logic [16:0]  exp_q[$];
  logic         nreq_valid = 1'b0;
  ebi_req_type  nreq = '0;
  logic         nreq_ready, nresp_valid, nsrdy;
  logic [15:0]  nresp_rdata, nad_in;
  logic [16:0]  ne;
  ebi_prb_type  nprb;
  ebi_pins_type npins;
  logic [16:0]  nexp_q[$];
  int           err_count = 0;
  int           num_checks = 0;
  int           cycles = 0;
  logic [7:0]   offs [8] = '{8'h10, 8'h12, 8'h18, 8'h20, 8'h44, 8'h50, 8'h66, 8'h80};

  always #2.5 mclk = ~mclk;

  ebi_top u_dut (.mclk, .rst_b, .ce, .req_valid, .req_ready, .req, .resp_valid, .resp_rdata, .chip_select_control, .prb,
    .prb_rdata, .intc_slave_mode, .pins, .ad_in, .srdy, .whb_n, .wlb_n, .single_byte_write_n(), .psram_cycle());
  ebi_mem_model u_mem (.mclk, .pins, .slow, .ad_in, .srdy);
  ebi_top #(.NARROW_BUS(1'b1)) u_narrow (.mclk, .rst_b, .ce, .req_valid(nreq_valid), .req_ready(nreq_ready),
    .req(nreq), .resp_valid(nresp_valid), .resp_rdata(nresp_rdata), .chip_select_control, .prb(nprb), .prb_rdata,
    .intc_slave_mode(), .pins(npins), .ad_in(nad_in), .srdy(nsrdy), .whb_n(), .wlb_n(),
    .single_byte_write_n(), .psram_cycle());
  ebi_mem_model #(.NARROW(1'b1)) u_nmem (.mclk, .pins(npins), .slow(1'b1), .ad_in(nad_in), .srdy(nsrdy));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      $display("unexpected %s expected %h seen %h", what, expv, seen);
      err_count++;
    end
  endtask : check

  task automatic final_report;
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // one request; the expected answer is queued before it is taken
  task automatic acc(input logic wr, io, wrd, input logic [19:0] a, input logic [15:0] d, input logic [16:0] x);
    while (req_ready !== 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
    slow = ~wr;
    req = '{wr, io, wrd, a, d};
    req_valid = 1'b1;
    exp_q.push_back(x);
    @(posedge mclk);
    #1 req_valid = 1'b0;
  endtask : acc

  // narrow variant: every external access waits on the ready pin, words go out as two byte cycles
  task automatic nacc(input logic wr, wrd, input logic [19:0] a, input logic [15:0] d, input logic [16:0] x);
    while (nreq_ready !== 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
    nreq = '{wr, 1'b0, wrd, a, d};
    nreq_valid = 1'b1;
    nexp_q.push_back(x);
    @(posedge mclk);
    #1 nreq_valid = 1'b0;
  endtask : nacc

  // an answer still owed when the wait runs out counts against the run
  task automatic drain;
    repeat (40) if (exp_q.size() + nexp_q.size() != 0) @(posedge mclk);
    #1;
    check("pending answers", 16'(exp_q.size() + nexp_q.size()), 16'h0000);
  endtask : drain

  // peripheral read data must stand through the cycle after the strobe
  always @(posedge mclk)
  begin
    #1 prb_rdata = prb.strobe ? {prb.offset, ~prb.offset} : (hold ? prb_rdata : 16'($urandom));
    hold = prb.strobe;
  end

  always @(posedge mclk)
    if (rst_b && resp_valid === 1'b1)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 17'h1dead;
      if (e[16])
        check("read data", resp_rdata, e[15:0]);
    end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      err_count++;
      final_report;
    end
  end

  always @(posedge mclk)
    if (rst_b && nresp_valid === 1'b1)
    begin
      ne = nexp_q.size() ? nexp_q.pop_front() : 17'h1dead;
      if (ne[16])
        check("narrow read data", nresp_rdata, ne[15:0]);
    end

  // a block transfer carries the whole request word, byte writes included
  always @(posedge mclk)
  begin
    if (prb.strobe === 1'b1)
      check("block data", prb.wdata, req.wdata);
    if (nprb.strobe === 1'b1)
      check("narrow block data", nprb.wdata, nreq.wdata);
  end

  initial
  begin
    void'($urandom(30487));
    repeat (3) @(posedge mclk);
    #1 rst_b = 1'b1;
    check("idle pins", {10'h0, pins.rd_n, pins.wr_n, pins.bhe_n, pins.ale, whb_n, wlb_n}, 16'h003b);
    for (int i = 0; i < 8; i++)
    begin
      wd = 16'($urandom);
      bd = 16'($urandom);
      adr = {3'h0, 1'($urandom), 1'b0, 14'($urandom), 1'b0};
      acc(1'b1, i[0], 1'b1, adr, wd, 17'h0);
      acc(1'b1, i[0], 1'b0, adr | 20'h1, bd, 17'h0);
      acc(1'b0, i[0], 1'b1, adr, 16'h0, {1'b1, bd[7:0], wd[7:0]});
    end
    acc(1'b0, 1'b0, 1'b1, 20'h0fffe, 16'h0, 17'h120ff);
    foreach (offs[k])
      acc(1'b0, 1'b0, 1'b1, {12'h0ff, offs[k]}, 16'h0, {1'b1, offs[k], ~offs[k]});
    acc(1'b1, 1'b0, 1'b0, 20'h0ff52, wd, 17'h0);
    acc(1'b1, 1'b0, 1'b1, 20'h0fffe, 16'h5034, 17'h0);
    drain;
    check("slave mode", {15'h0, intc_slave_mode}, 16'h0001);
    acc(1'b0, 1'b1, 1'b1, 20'h034fe, 16'h0, 17'h15034);
    acc(1'b0, 1'b1, 1'b1, 20'h03450, 16'h0, 17'h150af);
    drain;
    nacc(1'b1, 1'b1, adr, wd, 17'h0);
    nacc(1'b1, 1'b0, adr | 20'h1, bd, 17'h0);
    nacc(1'b0, 1'b1, adr, 16'h0, {1'b1, bd[7:0], wd[7:0]});
    // freeze mid-cycle: every stage, the ready synchroniser included, must hold its place
    repeat (3) @(posedge mclk);
    #1 ce = 1'b0;
    repeat (4) @(posedge mclk);
    #1 ce = 1'b1;
    nacc(1'b0, 1'b0, adr | 20'h1, 16'h0, {9'h100, bd[7:0]});
    nacc(1'b1, 1'b0, 20'h0ff52, bd, 17'h0);
    drain;
    final_report;
  end
endmodule : external_bus_interface_tb
